/* File: ivp_pkg.sv */
// Package with the constants and types of the interrupt entry block.
// Overview of operation
// - Any enabled request starts the vector prefetch.
// - Prefetch issued before the pipeline drain ends.
// - Prefetched words held until pipeline restart.
// - Lost priority: discard, fetch the winner's vector.
// - Prefetch works in all three interrupt modes.
// - Prefetch only while the enable bit is set.
// - Prefetch errors reported after drain, PC at vector.
// - Other exception wins: drop prefetch and its error.
// - Prologue needs shadow sets, controller mode, enable.
// - Prologue only after the interrupt wins.
// - Kernel or no kernel stack: previous set's r29.
// - Kernel stack, user code: shadow set one's r29.
// - Temporary pointer minus the stack decrement amount.
// - Return PC stored at pointer plus zero.
// - Processor state stored at pointer plus four.
// - Shadow control stored at pointer plus eight.
// - r29 written only after all three stores.
// - Requested priority copied into current priority.
// - Clear bit zeroes mode, error and exception levels.
// - Temporary pointer has no software access path.
// - Store fault: report type, set flag, keep PC.
// - Prologue is atomic except for store faults.
package ivp_pkg;
    localparam int unsigned XLEN            = 32;
    localparam logic [31:0] OFS_PC          = 32'h0000_0000;
    localparam logic [31:0] OFS_STATE       = 32'h0000_0004;
    localparam logic [31:0] OFS_SHADOW      = 32'h0000_0008;
    localparam logic [3:0]  WORD_STROBES    = 4'hf;
    localparam logic [3:0]  KERNEL_SET      = 4'h1;
    localparam logic [4:0]  SP_REG          = 5'h1d;
    localparam logic [1:0]  KSU_KERNEL      = 2'h0;
    // Processor state word field positions.
    localparam int unsigned ST_EXL          = 1;
    localparam int unsigned ST_ERL          = 2;
    localparam int unsigned ST_KSU_LO       = 3;
    localparam int unsigned ST_IPL_LO       = 10;
    localparam int unsigned IPL_W           = 8;
    typedef enum logic [1:0] {IRQ_MODE_COMPAT, IRQ_MODE_VECTORED, IRQ_MODE_EXT} ivp_irq_mode_t;
    typedef enum {S_IDLE, S_SPEC, S_WAIT, S_PRO_SP, S_PRO_DEC, S_PRO_ST0, S_PRO_ST1, S_PRO_ST2,
                  S_PRO_FIN, S_FETCH} ivp_state_t;
endpackage

/* File: ivp_entry.sv */
// Interrupt entry unit: speculative vector prefetch and automated prologue.
`timescale 1ns/1ps
module ivp_entry (
    input  wire logic        CLOCK,
    input  wire logic        RST,
    input  wire logic        IRQ_PENDING,
    input  wire logic [1:0]  IRQ_MODE,
    input  wire logic [31:0] IRQ_VECTOR,
    input  wire logic        PIPE_DRAINED,
    input  wire logic        PRIO_VALID,
    input  wire logic        PRIO_IS_IRQ,
    input  wire logic [31:0] PRIO_VECTOR,
    input  wire logic        VECTOR_PREFETCH_ENABLE,
    input  wire logic [3:0]  HIGHEST_SHADOW_SET,
    input  wire logic        EXT_CTRL_PRESENT,
    input  wire logic [4:0]  VECTOR_SPACING,
    input  wire logic        SPECIAL_VECTOR_SELECT,
    input  wire logic        BOOT_VECTOR_SELECT,
    input  wire logic        AUTO_PROLOGUE_ENABLE,
    input  wire logic        KERNEL_STACK_SELECT,
    input  wire logic [31:0] STACK_DECREMENT_AMOUNT,
    input  wire logic        CLEAR_EXC_LEVEL_ON_ENTRY,
    input  wire logic [31:0] EXCEPTION_RETURN_PC,
    input  wire logic [31:0] STATE_WORD,
    input  wire logic [31:0] SHADOW_SET_CONTROL_REG,
    input  wire logic [3:0]  PREV_SHADOW_SET,
    input  wire logic [3:0]  CUR_SHADOW_SET,
    input  wire logic [7:0]  REQUESTED_PRIORITY_LEVEL,
    output logic             FETCH_REQ,
    output logic [31:0]      FETCH_ADDR,
    input  wire logic        FETCH_DONE,
    input  wire logic [31:0] FETCH_DATA,
    input  wire logic        FETCH_ERR,
    output logic             INSTR_VALID,
    output logic [31:0]      INSTR_DATA,
    output logic             VEC_FETCH_ERR,
    output logic             GPR_RD_REQ,
    output logic [3:0]       GPR_RD_SET,
    output logic [4:0]       GPR_RD_IDX,
    input  wire logic        GPR_RD_VALID,
    input  wire logic [31:0] GPR_RD_DATA,
    output logic             GPR_WR_EN,
    output logic [3:0]       GPR_WR_SET,
    output logic [4:0]       GPR_WR_IDX,
    output logic [31:0]      GPR_WR_DATA,
    output logic             STORE_REQ,
    output logic [31:0]      STORE_ADDR,
    output logic [31:0]      STORE_DATA,
    output logic [3:0]       STORE_STROBE,
    input  wire logic        STORE_DONE,
    input  wire logic        STORE_FAULT,
    input  wire logic [4:0]  STORE_FAULT_CODE,
    output logic             STATE_WR_EN,
    output logic [31:0]      STATE_WR_DATA,
    output logic             PROLOGUE_FAULT_FLAG,
    output logic [4:0]       FAULT_CODE,
    output logic             PROLOGUE_BUSY
);
    // Everything below runs on the one core clock; all request inputs come from core logic.
    ivp_pkg::ivp_state_t state_ff;
    ivp_pkg::ivp_state_t nxt_state;
    logic        hold_valid_ff;
    logic [31:0] hold_data_ff;
    logic        hold_err_ff;
    logic        inflight_ff;
    logic [31:0] temp_stack_ptr_ff;
    logic        store_sent_ff;
    logic        rd_sent_ff;
    logic        pro_ok;
    logic        mode_ok;
    logic        use_kernel;

    // Stack address of each prologue store.
    function automatic logic [31:0] slot_addr(input logic [31:0] base, input logic [31:0] ofs);
        slot_addr = base + ofs;
    endfunction

    // Controller mode is fully enabled only with every condition true.
    assign mode_ok    = EXT_CTRL_PRESENT && (VECTOR_SPACING != 5'h00) && SPECIAL_VECTOR_SELECT
                        && !BOOT_VECTOR_SELECT;
    assign pro_ok     = (HIGHEST_SHADOW_SET != 4'h0) && mode_ok && AUTO_PROLOGUE_ENABLE;
    assign use_kernel = KERNEL_STACK_SELECT &&
        (STATE_WORD[ivp_pkg::ST_KSU_LO +: 2] != ivp_pkg::KSU_KERNEL);

    // Sequencer for entry; mode input does not alter the prefetch path.
    always_comb begin
        nxt_state = state_ff;
        case (state_ff)
            ivp_pkg::S_IDLE: begin
                if (IRQ_PENDING && VECTOR_PREFETCH_ENABLE) begin
                    nxt_state = ivp_pkg::S_SPEC;
                end else if (PRIO_VALID) begin
                    nxt_state = ivp_pkg::S_WAIT;
                end
            end
            ivp_pkg::S_SPEC: begin
                if (PRIO_VALID && PIPE_DRAINED) begin
                    if (!PRIO_IS_IRQ) begin
                        nxt_state = ivp_pkg::S_FETCH;
                    end else if (pro_ok) begin
                        nxt_state = ivp_pkg::S_PRO_SP;
                    end else begin
                        nxt_state = ivp_pkg::S_IDLE;
                    end
                end
            end
            ivp_pkg::S_WAIT: begin
                if (PIPE_DRAINED) begin
                    if (PRIO_IS_IRQ && pro_ok) begin
                        nxt_state = ivp_pkg::S_PRO_SP;
                    end else begin
                        nxt_state = ivp_pkg::S_FETCH;
                    end
                end
            end
            ivp_pkg::S_PRO_SP: begin
                if (GPR_RD_VALID) begin
                    nxt_state = ivp_pkg::S_PRO_DEC;
                end
            end
            ivp_pkg::S_PRO_DEC: nxt_state = ivp_pkg::S_PRO_ST0;
            ivp_pkg::S_PRO_ST0: begin
                if (STORE_FAULT) begin
                    nxt_state = ivp_pkg::S_IDLE;
                end else if (STORE_DONE) begin
                    nxt_state = ivp_pkg::S_PRO_ST1;
                end
            end
            ivp_pkg::S_PRO_ST1: begin
                if (STORE_FAULT) begin
                    nxt_state = ivp_pkg::S_IDLE;
                end else if (STORE_DONE) begin
                    nxt_state = ivp_pkg::S_PRO_ST2;
                end
            end
            ivp_pkg::S_PRO_ST2: begin
                if (STORE_FAULT) begin
                    nxt_state = ivp_pkg::S_IDLE;
                end else if (STORE_DONE) begin
                    nxt_state = ivp_pkg::S_PRO_FIN;
                end
            end
            ivp_pkg::S_PRO_FIN: nxt_state = ivp_pkg::S_FETCH;
            ivp_pkg::S_FETCH: begin
                if (FETCH_DONE && !inflight_ff) begin
                    nxt_state = ivp_pkg::S_IDLE;
                end
            end
            default: nxt_state = ivp_pkg::S_IDLE;
        endcase
    end

    // State register.
    always_ff @(posedge CLOCK) begin
        if (RST) begin
            state_ff <= ivp_pkg::S_IDLE;
        end else begin
            state_ff <= nxt_state;
        end
    end

    // Fetch request: speculative at request time, otherwise after the decision.
    always_ff @(posedge CLOCK) begin
        if (RST) begin
            FETCH_REQ   <= 1'b0;
            FETCH_ADDR  <= 32'h0000_0000;
            inflight_ff <= 1'b0;
        end else begin
            FETCH_REQ <= 1'b0;
            if (state_ff == ivp_pkg::S_IDLE && nxt_state == ivp_pkg::S_SPEC) begin
                FETCH_REQ   <= 1'b1;
                FETCH_ADDR  <= IRQ_VECTOR;
                inflight_ff <= 1'b1;
            end else if (state_ff != ivp_pkg::S_FETCH && nxt_state == ivp_pkg::S_FETCH) begin
                FETCH_REQ   <= 1'b1;
                FETCH_ADDR  <= PRIO_IS_IRQ ? IRQ_VECTOR : PRIO_VECTOR;
                inflight_ff <= inflight_ff && !FETCH_DONE; // A late speculative answer is still owed and must be skipped.
            end else if (FETCH_DONE) begin
                inflight_ff <= 1'b0;
            end
        end
    end

    // Prefetched word and any error are held, never handed over early.
    always_ff @(posedge CLOCK) begin
        if (RST) begin
            hold_valid_ff <= 1'b0;
            hold_data_ff  <= 32'h0000_0000;
            hold_err_ff   <= 1'b0;
        end else if (nxt_state == ivp_pkg::S_FETCH && state_ff != ivp_pkg::S_FETCH && !PRIO_IS_IRQ) begin
            hold_valid_ff <= 1'b0;
            hold_err_ff   <= 1'b0;
        end else if (state_ff == ivp_pkg::S_SPEC && inflight_ff && FETCH_DONE) begin
            hold_valid_ff <= 1'b1;
            hold_data_ff  <= FETCH_DATA;
            hold_err_ff   <= FETCH_ERR;
        end else if (state_ff == ivp_pkg::S_IDLE) begin
            hold_valid_ff <= 1'b0;
            hold_err_ff   <= 1'b0;
        end
    end

    // Delivery at pipeline restart: held word when the prefetched interrupt wins with no prologue, else fresh fetch.
    always_ff @(posedge CLOCK) begin
        if (RST) begin
            INSTR_VALID   <= 1'b0;
            INSTR_DATA    <= 32'h0000_0000;
            VEC_FETCH_ERR <= 1'b0;
        end else begin
            INSTR_VALID   <= 1'b0;
            VEC_FETCH_ERR <= 1'b0;
            if (state_ff == ivp_pkg::S_SPEC && nxt_state == ivp_pkg::S_IDLE && hold_valid_ff) begin
                INSTR_VALID   <= !hold_err_ff;
                INSTR_DATA    <= hold_data_ff;
                VEC_FETCH_ERR <= hold_err_ff;
            end else if (state_ff == ivp_pkg::S_FETCH && FETCH_DONE && !inflight_ff) begin
                INSTR_VALID   <= !FETCH_ERR;
                INSTR_DATA    <= FETCH_DATA;
                VEC_FETCH_ERR <= FETCH_ERR;
            end
        end
    end

    // Stack pointer source read and internal temporary pointer.
    always_ff @(posedge CLOCK) begin
        if (RST) begin
            GPR_RD_REQ        <= 1'b0;
            GPR_RD_SET        <= 4'h0;
            GPR_RD_IDX        <= 5'h00;
            rd_sent_ff        <= 1'b0;
            temp_stack_ptr_ff <= 32'h0000_0000;
        end else begin
            GPR_RD_REQ <= 1'b0;
            if (state_ff == ivp_pkg::S_PRO_SP && !rd_sent_ff) begin
                GPR_RD_REQ <= 1'b1;
                GPR_RD_IDX <= ivp_pkg::SP_REG;
                GPR_RD_SET <= use_kernel ? ivp_pkg::KERNEL_SET : PREV_SHADOW_SET;
                rd_sent_ff <= 1'b1;
            end else if (state_ff != ivp_pkg::S_PRO_SP) begin
                rd_sent_ff <= 1'b0;
            end
            if (state_ff == ivp_pkg::S_PRO_SP && GPR_RD_VALID) begin
                temp_stack_ptr_ff <= GPR_RD_DATA;
            end else if (state_ff == ivp_pkg::S_PRO_DEC) begin
                temp_stack_ptr_ff <= temp_stack_ptr_ff - STACK_DECREMENT_AMOUNT;
            end
        end
    end

    // Three ordered word stores, one outstanding at a time.
    always_ff @(posedge CLOCK) begin
        if (RST) begin
            STORE_REQ     <= 1'b0;
            STORE_ADDR    <= 32'h0000_0000;
            STORE_DATA    <= 32'h0000_0000;
            STORE_STROBE  <= 4'h0;
            store_sent_ff <= 1'b0;
        end else begin
            STORE_REQ <= 1'b0;
            if (STORE_DONE || STORE_FAULT || state_ff == ivp_pkg::S_PRO_DEC) begin
                store_sent_ff <= 1'b0;
            end else if (!store_sent_ff) begin
                case (state_ff)
                    ivp_pkg::S_PRO_ST0: begin
                        STORE_REQ     <= 1'b1;
                        STORE_ADDR    <= slot_addr(temp_stack_ptr_ff, ivp_pkg::OFS_PC);
                        STORE_DATA    <= EXCEPTION_RETURN_PC;
                        STORE_STROBE  <= ivp_pkg::WORD_STROBES;
                        store_sent_ff <= 1'b1;
                    end
                    ivp_pkg::S_PRO_ST1: begin
                        STORE_REQ     <= 1'b1;
                        STORE_ADDR    <= slot_addr(temp_stack_ptr_ff, ivp_pkg::OFS_STATE);
                        STORE_DATA    <= STATE_WORD;
                        STORE_STROBE  <= ivp_pkg::WORD_STROBES;
                        store_sent_ff <= 1'b1;
                    end
                    ivp_pkg::S_PRO_ST2: begin
                        STORE_REQ     <= 1'b1;
                        STORE_ADDR    <= slot_addr(temp_stack_ptr_ff, ivp_pkg::OFS_SHADOW);
                        STORE_DATA    <= SHADOW_SET_CONTROL_REG;
                        STORE_STROBE  <= ivp_pkg::WORD_STROBES;
                        store_sent_ff <= 1'b1;
                    end
                    default: store_sent_ff <= 1'b0;
                endcase
            end
        end
    end

    // Final updates: stack pointer write-back and state word change.
    always_ff @(posedge CLOCK) begin
        if (RST) begin
            GPR_WR_EN     <= 1'b0;
            GPR_WR_SET    <= 4'h0;
            GPR_WR_IDX    <= 5'h00;
            GPR_WR_DATA   <= 32'h0000_0000;
            STATE_WR_EN   <= 1'b0;
            STATE_WR_DATA <= 32'h0000_0000;
        end else begin
            GPR_WR_EN   <= 1'b0;
            STATE_WR_EN <= 1'b0;
            if (state_ff == ivp_pkg::S_PRO_FIN) begin
                GPR_WR_EN   <= 1'b1;
                GPR_WR_SET  <= CUR_SHADOW_SET;
                GPR_WR_IDX  <= ivp_pkg::SP_REG;
                GPR_WR_DATA <= temp_stack_ptr_ff;
                STATE_WR_EN <= 1'b1;
                STATE_WR_DATA <= STATE_WORD;
                STATE_WR_DATA[ivp_pkg::ST_IPL_LO +: ivp_pkg::IPL_W] <= REQUESTED_PRIORITY_LEVEL;
                if (CLEAR_EXC_LEVEL_ON_ENTRY) begin
                    STATE_WR_DATA[ivp_pkg::ST_KSU_LO +: 2] <= 2'h0;
                    STATE_WR_DATA[ivp_pkg::ST_ERL]         <= 1'b0;
                    STATE_WR_DATA[ivp_pkg::ST_EXL]         <= 1'b0;
                end
            end
        end
    end

    // Fault reporting and busy indication.
    always_ff @(posedge CLOCK) begin
        if (RST) begin
            PROLOGUE_FAULT_FLAG <= 1'b0;
            FAULT_CODE          <= 5'h00;
            PROLOGUE_BUSY       <= 1'b0;
        end else begin
            PROLOGUE_FAULT_FLAG <= 1'b0;
            PROLOGUE_BUSY <= (nxt_state inside {ivp_pkg::S_PRO_SP, ivp_pkg::S_PRO_DEC, ivp_pkg::S_PRO_ST0,
                              ivp_pkg::S_PRO_ST1, ivp_pkg::S_PRO_ST2, ivp_pkg::S_PRO_FIN});
            if (state_ff inside {ivp_pkg::S_PRO_ST0, ivp_pkg::S_PRO_ST1, ivp_pkg::S_PRO_ST2} && STORE_FAULT) begin
                PROLOGUE_FAULT_FLAG <= 1'b1;
                FAULT_CODE          <= STORE_FAULT_CODE;
            end
        end
    end

    // Checks on the entry sequence.
    no_pf_off_a: assert property (@(posedge CLOCK) disable iff (RST)
        (state_ff == ivp_pkg::S_IDLE && !VECTOR_PREFETCH_ENABLE) |=> !(state_ff == ivp_pkg::S_SPEC))
        else $error("Prefetch started while disabled.");
    pf_issue_a: assert property (@(posedge CLOCK) disable iff (RST)
        (state_ff == ivp_pkg::S_IDLE && IRQ_PENDING && VECTOR_PREFETCH_ENABLE) |=> FETCH_REQ && FETCH_ADDR == $past(IRQ_VECTOR))
        else $error("Vector prefetch not issued.");
    hold_back_a: assert property (@(posedge CLOCK) disable iff (RST)
        (state_ff == ivp_pkg::S_SPEC && !PRIO_VALID) |=> !INSTR_VALID)
        else $error("Prefetched word delivered early.");
    err_drop_a: assert property (@(posedge CLOCK) disable iff (RST)
        (state_ff == ivp_pkg::S_SPEC && PRIO_VALID && PIPE_DRAINED && !PRIO_IS_IRQ) |=> !hold_valid_ff && !hold_err_ff ##1 !VEC_FETCH_ERR)
        else $error("Abandoned prefetch not dropped.");
    no_pro_exc_a: assert property (@(posedge CLOCK) disable iff (RST)
        (state_ff == ivp_pkg::S_WAIT && PIPE_DRAINED && !PRIO_IS_IRQ) |=> state_ff == ivp_pkg::S_FETCH)
        else $error("Prologue ran for a non-interrupt exception.");
    pro_gate_a: assert property (@(posedge CLOCK) disable iff (RST)
        (state_ff != ivp_pkg::S_PRO_SP ##1 state_ff == ivp_pkg::S_PRO_SP) |-> $past(pro_ok))
        else $error("Prologue entered without its conditions.");
    sp_dec_a: assert property (@(posedge CLOCK) disable iff (RST)
        (state_ff == ivp_pkg::S_PRO_DEC) |=> temp_stack_ptr_ff == $past(temp_stack_ptr_ff) - $past(STACK_DECREMENT_AMOUNT))
        else $error("Stack pointer not decremented.");
    st1_addr_a: assert property (@(posedge CLOCK) disable iff (RST)
        (STORE_REQ && $past(state_ff) == ivp_pkg::S_PRO_ST1) |-> STORE_ADDR == temp_stack_ptr_ff + ivp_pkg::OFS_STATE)
        else $error("State store address wrong.");
    wr_late_a: assert property (@(posedge CLOCK) disable iff (RST)
        GPR_WR_EN |-> $past(state_ff) == ivp_pkg::S_PRO_FIN)
        else $error("Stack pointer written before stores ended.");
    fault_flag_a: assert property (@(posedge CLOCK) disable iff (RST)
        (state_ff inside {ivp_pkg::S_PRO_ST0, ivp_pkg::S_PRO_ST1, ivp_pkg::S_PRO_ST2} && STORE_FAULT)
        |=> PROLOGUE_FAULT_FLAG && !GPR_WR_EN && state_ff == ivp_pkg::S_IDLE)
        else $error("Store fault not reported.");
    spec_win_c: cover property (@(posedge CLOCK) state_ff == ivp_pkg::S_SPEC ##[1:20] INSTR_VALID);
    spec_lose_c: cover property (@(posedge CLOCK) state_ff == ivp_pkg::S_SPEC ##1 state_ff == ivp_pkg::S_FETCH);
    pro_done_c: cover property (@(posedge CLOCK) GPR_WR_EN && STATE_WR_EN);
    pro_fault_c: cover property (@(posedge CLOCK) PROLOGUE_FAULT_FLAG);
endmodule

/* File: ivp_mem_model.sv */
// Behavioural fetch path, register file port and store path facing the entry unit.
`timescale 1ns/1ps
module ivp_mem_model (
    input  wire logic        CLOCK,
    input  wire logic        RST,
    input  wire logic        FETCH_REQ,
    input  wire logic [31:0] FETCH_ADDR,
    input  wire logic        FETCH_BAD,
    input  wire logic        GPR_RD_REQ,
    input  wire logic [3:0]  GPR_RD_SET,
    input  wire logic        STORE_REQ,
    input  wire logic [1:0]  FAULT_AT,
    output logic             FETCH_DONE,
    output logic [31:0]      FETCH_DATA,
    output logic             FETCH_ERR,
    output logic             GPR_RD_VALID,
    output logic [31:0]      GPR_RD_DATA,
    output logic             STORE_DONE,
    output logic             STORE_FAULT,
    output logic [4:0]       STORE_FAULT_CODE
);
    logic [31:0] fa_ff;
    logic [31:0] tick_ff;
    logic [3:0]  set_ff;
    logic [2:0]  f_ff;
    logic [2:0]  g_ff;
    logic [2:0]  s_ff;
    logic [1:0]  sn_ff;
    // Each request is answered four cycles later unless another follows within two cycles; idle data lines carry a changing pattern.
    always_ff @(posedge CLOCK) begin
        tick_ff          <= RST ? 32'h0 : tick_ff + 32'h1;
        fa_ff            <= FETCH_REQ ? FETCH_ADDR : fa_ff;
        set_ff           <= GPR_RD_REQ ? GPR_RD_SET : set_ff;
        f_ff             <= RST ? 3'h0 : FETCH_REQ ? 3'h3 : (f_ff != 3'h0 ? f_ff - 3'h1 : 3'h0);
        g_ff             <= RST ? 3'h0 : GPR_RD_REQ ? 3'h3 : (g_ff != 3'h0 ? g_ff - 3'h1 : 3'h0);
        s_ff             <= RST ? 3'h0 : STORE_REQ ? 3'h3 : (s_ff != 3'h0 ? s_ff - 3'h1 : 3'h0);
        sn_ff            <= GPR_RD_REQ ? 2'h0 : (s_ff == 3'h1 ? sn_ff + 2'h1 : sn_ff);
        FETCH_DONE       <= !RST && f_ff == 3'h1;
        FETCH_ERR        <= !RST && f_ff == 3'h1 && FETCH_BAD;
        FETCH_DATA       <= f_ff == 3'h1 ? ~fa_ff : tick_ff;
        GPR_RD_VALID     <= !RST && g_ff == 3'h1;
        GPR_RD_DATA      <= g_ff == 3'h1 ? {16'h0, 4'h4, set_ff, 8'h00} : tick_ff;
        STORE_DONE       <= !RST && s_ff == 3'h1 && sn_ff != FAULT_AT;
        STORE_FAULT      <= !RST && s_ff == 3'h1 && sn_ff == FAULT_AT;
        STORE_FAULT_CODE <= s_ff == 3'h1 ? 5'h0c : tick_ff[4:0];
    end
endmodule

/* File: tb.sv */
// Self-checking testbench for the interrupt entry unit.
`timescale 1ns/1ps
module tb;
    logic CLOCK = 1'b0, RST = 1'b1, IRQ_PENDING = 1'b0, PIPE_DRAINED = 1'b0, PRIO_VALID = 1'b0, PRIO_IS_IRQ = 1'b0;
    logic VECTOR_PREFETCH_ENABLE = 1'b0, EXT_CTRL_PRESENT = 1'b1, SPECIAL_VECTOR_SELECT = 1'b1, FETCH_BAD = 1'b0;
    logic BOOT_VECTOR_SELECT = 1'b0, AUTO_PROLOGUE_ENABLE = 1'b0, KERNEL_STACK_SELECT = 1'b0;
    logic CLEAR_EXC_LEVEL_ON_ENTRY = 1'b0, FETCH_DONE, FETCH_ERR, GPR_RD_VALID, STORE_DONE, STORE_FAULT;
    logic FETCH_REQ, INSTR_VALID, VEC_FETCH_ERR, GPR_RD_REQ, GPR_WR_EN, STORE_REQ, STATE_WR_EN;
    logic PROLOGUE_FAULT_FLAG, PROLOGUE_BUSY;
    logic [1:0]  IRQ_MODE = 2'h0, FAULT_AT = 2'h3;
    logic [3:0]  HIGHEST_SHADOW_SET = 4'h3, PREV_SHADOW_SET = 4'h2, CUR_SHADOW_SET = 4'h3;
    logic [3:0]  GPR_RD_SET, GPR_WR_SET, STORE_STROBE;
    logic [4:0]  VECTOR_SPACING = 5'h01, STORE_FAULT_CODE, GPR_RD_IDX, GPR_WR_IDX, FAULT_CODE;
    logic [7:0]  REQUESTED_PRIORITY_LEVEL = 8'h2c;
    logic [31:0] IRQ_VECTOR = 32'h0000_0200, PRIO_VECTOR = 32'h0000_0180, STACK_DECREMENT_AMOUNT = 32'h10;
    logic [31:0] EXCEPTION_RETURN_PC = 32'h1234_5678, STATE_WORD = 32'h6, SHADOW_SET_CONTROL_REG = 32'h0000_3c21;
    logic [31:0] FETCH_ADDR, FETCH_DATA, INSTR_DATA, GPR_RD_DATA, GPR_WR_DATA, STORE_ADDR, STORE_DATA, STATE_WR_DATA;
    int          n_f, n_i, n_v, n_s, n_w, n_x, n_t, n_b, err_total = 0, compares = 0, cyc = 0;
    logic [31:0] f_addr, i_data, w_data, x_data, sp, s_addr [3], s_data [3];
    logic [8:0]  w_tag, r_tag;
    logic [3:0]  s_strb;
    logic [4:0]  code;

    ivp_entry     i_ivp_entry (.*);
    ivp_mem_model i_ivp_mem_model (.*);

    always #12.5 CLOCK = ~CLOCK;

    // Records every output pulse of the unit together with what it carried.
    always @(posedge CLOCK) begin
        cyc++;
        if (FETCH_REQ) begin n_f++; f_addr = FETCH_ADDR; end
        if (INSTR_VALID) begin n_i++; i_data = INSTR_DATA; end
        if (VEC_FETCH_ERR) n_v++;
        if (GPR_RD_REQ) r_tag = {GPR_RD_SET, GPR_RD_IDX};
        if (PROLOGUE_BUSY) n_b++;
        if (STORE_REQ && n_s < 3) begin s_addr[n_s] = STORE_ADDR; s_data[n_s] = STORE_DATA; s_strb = STORE_STROBE; n_s++; end
        if (GPR_WR_EN) begin n_w++; w_data = GPR_WR_DATA; w_tag = {GPR_WR_SET, GPR_WR_IDX}; end
        if (STATE_WR_EN) begin n_x++; x_data = STATE_WR_DATA; end
        if (PROLOGUE_FAULT_FLAG) begin n_t++; code = FAULT_CODE; end
        if (cyc == 6000) begin
            err_total++;
            tally_and_finish();
        end
    end

    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        compares++;
        if (seen !== exp) begin
            err_total++;
            $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask

    // One interrupt entry: signal, let the prefetch run, then resolve the priority decision.
    task automatic run(input logic pf, auto_prologue_enable, win, bad, input logic [1:0] fat);
        n_f = 0; n_i = 0; n_v = 0; n_s = 0; n_w = 0; n_x = 0; n_t = 0; n_b = 0;
        @(posedge CLOCK);
        VECTOR_PREFETCH_ENABLE <= pf;
        AUTO_PROLOGUE_ENABLE <= auto_prologue_enable;
        PRIO_IS_IRQ <= win;
        FETCH_BAD <= bad;
        FAULT_AT <= fat;
        IRQ_PENDING <= 1'b1;
        repeat (8) @(posedge CLOCK);
        check(n_f, {31'h0, pf});
        check(n_i, 0);
        check(n_v, 0);
        PIPE_DRAINED <= 1'b1;
        PRIO_VALID <= 1'b1;
        FETCH_BAD <= 1'b0; // Only the speculative fetch is made to fail.
        repeat (pf ? 1 : 2) @(posedge CLOCK);
        IRQ_PENDING <= 1'b0;
        PIPE_DRAINED <= 1'b0;
        PRIO_VALID <= 1'b0;
        for (int k = 0; k < 80 && n_i + n_t + n_v == 0; k++) @(posedge CLOCK);
        err_total += (n_i + n_t + n_v == 0); // An entry that never ends counts as a mismatch.
        repeat (4) @(posedge CLOCK);
        $display("test done at %0t", $time);
    endtask

    task automatic tally_and_finish;
        $display("compares %0d mismatches %0d", compares, err_total);
        if (err_total == 0 && compares > 0) $display("Result: passed");
        else $display("Result: failed");
        $finish;
    endtask

    initial begin
        repeat (5) @(posedge CLOCK);
        RST <= 1'b0;
        for (int m = 0; m < 3; m++) begin
            IRQ_MODE <= m[1:0];
            run(1'b1, 1'b0, 1'b1, 1'b0, 2'h3);
            check(f_addr, IRQ_VECTOR);
            check(i_data, ~IRQ_VECTOR);
        end
        run(1'b1, 1'b0, 1'b0, 1'b1, 2'h3);
        check(f_addr, PRIO_VECTOR);
        check(i_data, ~PRIO_VECTOR);
        check(n_v, 0);
        run(1'b1, 1'b0, 1'b1, 1'b1, 2'h3);
        check(n_v, 1);
        run(1'b0, 1'b0, 1'b1, 1'b0, 2'h3);
        check(f_addr, IRQ_VECTOR);
        for (int c = 0; c < 3; c++) begin
            KERNEL_STACK_SELECT <= c > 0;
            CLEAR_EXC_LEVEL_ON_ENTRY <= c != 1;
            STATE_WORD <= c != 1 ? 32'h16 : 32'h6;
            run(1'b1, 1'b1, 1'b1, 1'b0, 2'h3);
            sp = {16'h0, 4'h4, c == 2 ? 4'h1 : PREV_SHADOW_SET, 8'h00} - STACK_DECREMENT_AMOUNT;
            check(r_tag, {c == 2 ? 4'h1 : PREV_SHADOW_SET, 5'h1d});
            check(s_addr[0], sp);
            check(s_addr[1], sp + 32'h4);
            check(s_addr[2], sp + 32'h8);
            check(s_data[0], EXCEPTION_RETURN_PC);
            check(s_data[2], SHADOW_SET_CONTROL_REG);
            check(s_data[1], STATE_WORD);
            check(s_strb, 4'hf);
            check(n_w, 1);
            check(w_tag, {CUR_SHADOW_SET, 5'h1d});
            check(n_b != 0, 1);
            check(w_data, sp);
            check(x_data, (STATE_WORD & (c != 1 ? 32'hfffc_03e1 : 32'hfffc_03ff)) | 32'hb000);
            check(f_addr, IRQ_VECTOR);
        end
        run(1'b1, 1'b1, 1'b0, 1'b0, 2'h3);
        check(n_s, 0);
        HIGHEST_SHADOW_SET <= 4'h0;
        run(1'b1, 1'b1, 1'b1, 1'b0, 2'h3);
        check(n_s, 0);
        check(n_b, 0);
        HIGHEST_SHADOW_SET <= 4'h3;
        run(1'b1, 1'b1, 1'b1, 1'b0, 2'h1);
        check(n_t, 1);
        check(code, 5'h0c);
        check(n_w + n_x, 0);
        tally_and_finish();
    end
endmodule
